// file: verilog/scfh_pkg.sv
// Constants, types and frame codes of the serial command frame handler.
// Assumes one byte stream each way, with the UART outside this block.
// ======================================================================
// Overview of operation
// RQ1 - Frame opens with fixed start byte
// RQ2 - Descriptor: command id, direction, seven-bit length
// RQ3 - Descriptor sent high bit first, id first
// RQ4 - Data byte count equals length field
// RQ5 - Check byte is XOR of descriptor, data
// RQ6 - Frame closes with fixed end byte
// RQ7 - Answer every frame with ACK or NAK; a frame cut off by the byte gap time-out gets no answer
// RQ8 - Multi-byte values travel low byte first
// RQ9 - Order, check, count all pass gives ACK
// RQ10 - Byte gap over limit enters discard
// RQ11 - Discard ends after long line silence
// RQ12 - Known read: ACK then data frame
// RQ13 - Unknown read: ACK only, no frame
// RQ14 - Read carries no data; length is expected
// RQ15 - Host deems silence or late frame failure
// RQ16 - Write ACKed; unknown id changes nothing
// RQ17 - Written data applied without range checks
// RQ18 - Host may verify writes by reading back
// RQ19 - Response frame echoes id, flag cleared
// RQ20 - Validated frames handed to parameter store
`default_nettype none

package scfh_pkg;

  // ====================================================================
  // Frame codes
  localparam logic [7:0] FRAME_START_BYTE = 8'h02;
  localparam logic [7:0] FRAME_END_BYTE   = 8'h03;
  localparam logic [7:0] ACK_BYTE         = 8'h06;
  localparam logic [7:0] NAK_BYTE         = 8'h15;

  // ====================================================================
  // Descriptor layout and buffer
  localparam int unsigned DIR_BIT   = 7;
  localparam int unsigned LEN_W     = 7;
  localparam int unsigned MEM_DEPTH = 128;

  // ====================================================================
  // Timing
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned GAP_MS         = 1000;
  localparam int unsigned SILENCE_MS     = 1500;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned GAP_CYCLES     = GAP_MS * CYC_PER_MS;
  localparam int unsigned SILENCE_CYCLES = SILENCE_MS * CYC_PER_MS;

  // ====================================================================
  // States
  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_ID       = 4'b0001,
    ST_LEN      = 4'b0010,
    ST_DATA     = 4'b0011,
    ST_CHECK    = 4'b0100,
    ST_END      = 4'b0101,
    ST_ACK      = 4'b0110,
    ST_ACK_WAIT = 4'b0111,
    ST_WRITE    = 4'b1000,
    ST_FETCH    = 4'b1001,
    ST_RESP     = 4'b1010,
    ST_DISCARD  = 4'b1011
  } scfh_state_type;

  typedef enum logic [2:0] {
    STEP_START = 3'b000,
    STEP_ID    = 3'b001,
    STEP_LEN   = 3'b010,
    STEP_DATA  = 3'b011,
    STEP_BCC   = 3'b100,
    STEP_END   = 3'b101
  } scfh_step_type;

endpackage

`default_nettype wire

// file: verilog/scfh_mem_if.sv
// Port bundle between the frame handler and its data buffer.
// Assumes a single clock shared by both ends.
`default_nettype none

interface scfh_mem_if;
  logic       wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_addr, output rd_data);
endinterface

`default_nettype wire

// file: verilog/scfh_frame_mem.sv
// Data byte buffer of one frame, registered read.
// Assumes the controller allows one cycle of read latency.
`default_nettype none

module scfh_frame_mem (
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  scfh_mem_if.mem   mem_port
);

  logic [7:0] store_reg [scfh_pkg::MEM_DEPTH];
  logic [7:0] rd_data_reg;

  // Array left unreset: contents only matter after being written
  always_ff @(posedge i_core_clk)
  begin
    if (mem_port.wr_en)
      store_reg[mem_port.wr_addr] <= mem_port.wr_data;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rd_data_reg <= 8'h00;
    else
      rd_data_reg <= store_reg[mem_port.rd_addr];
  end

  assign mem_port.rd_data = rd_data_reg;

endmodule

`default_nettype wire

// file: verilog/scfh_gap_timer.sv
// Idle-time counter for the receive line.
// Assumes i_restart pulses on every received byte.
`default_nettype none

module scfh_gap_timer #(
  parameter int unsigned GAP_CYCLES     = scfh_pkg::GAP_CYCLES,
  parameter int unsigned SILENCE_CYCLES = scfh_pkg::SILENCE_CYCLES
) (
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  input  wire logic i_restart,
  output var  logic o_gap_over,
  output var  logic o_silent
);

  logic [31:0] count_reg;
  logic [31:0] count_next;

  // Saturates so the counter never wraps back into a short gap
  assign count_next = i_restart ? 32'h0000_0000 :
                      (count_reg >= SILENCE_CYCLES) ? count_reg :
                      count_reg + 32'h0000_0001;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      count_reg <= 32'h0000_0000;
    else
      count_reg <= count_next;
  end

  assign o_gap_over = (count_reg > GAP_CYCLES);
  assign o_silent   = (count_reg >= SILENCE_CYCLES);

endmodule

`default_nettype wire

// file: verilog/scfh_top.sv
// Frame receiver, checker, acknowledger and response builder.
// Assumes byte strobes from a UART and a parameter store that answers
// i_cmd_known combinationally from o_cmd_id.
`default_nettype none

module scfh_top #(
  parameter int unsigned GAP_CYCLES     = scfh_pkg::GAP_CYCLES,
  parameter int unsigned SILENCE_CYCLES = scfh_pkg::SILENCE_CYCLES
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  output var  logic       o_tx_valid,
  output var  logic [7:0] o_tx_data,
  input  wire logic       i_tx_ready,
  output var  logic       o_cmd_valid,
  output var  logic [7:0] o_cmd_id,
  output var  logic       o_cmd_read,
  output var  logic [6:0] o_cmd_len,
  input  wire logic       i_cmd_known,
  output var  logic       o_wr_valid,
  output var  logic [6:0] o_wr_index,
  output var  logic [7:0] o_wr_data,
  output var  logic       o_rd_req,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data
);

  // ====================================================================
  // Helpers
  function automatic logic in_frame(scfh_pkg::scfh_state_type s);
    return (s == scfh_pkg::ST_ID) || (s == scfh_pkg::ST_LEN) ||
           (s == scfh_pkg::ST_DATA) || (s == scfh_pkg::ST_CHECK) ||
           (s == scfh_pkg::ST_END);
  endfunction

  function automatic logic [7:0] fold(logic [7:0] acc, logic [7:0] b);
    return acc ^ b;
  endfunction

  // ====================================================================
  // State
  scfh_pkg::scfh_state_type state_reg, state_next;
  scfh_pkg::scfh_step_type  step_reg, step_next;
  logic [7:0] id_reg, id_next;
  logic       read_reg, read_next;
  logic [6:0] len_reg, len_next;
  logic [6:0] idx_reg, idx_next;
  logic [7:0] bcc_reg, bcc_next;
  logic       bcc_ok_reg, bcc_ok_next;
  logic       good_reg, good_next;
  logic       known_reg, known_next;
  logic       phase_reg, phase_next;
  logic       tx_valid_reg, tx_valid_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic       cmd_valid_reg, cmd_valid_next;
  logic       wr_valid_reg, wr_valid_next;
  logic [6:0] wr_index_reg, wr_index_next;
  logic [7:0] wr_data_reg, wr_data_next;
  logic       mem_we;

  scfh_mem_if mem_bus ();

  wire logic       gap_over;
  wire logic       silent;
  wire logic [6:0] len_minus_one = len_reg - 7'h01;
  wire logic       last_byte     = (idx_reg == len_minus_one);
  wire logic       tx_free       = !tx_valid_reg;
  wire logic       tx_taken      = tx_valid_reg && i_tx_ready;
  wire logic [7:0] rdata         = mem_bus.rd_data;
  wire logic       enter_discard = (state_next == scfh_pkg::ST_DISCARD) &&
                                   (state_reg != scfh_pkg::ST_DISCARD);
  wire logic       start_seen    = i_rx_valid &&
                                   (i_rx_data == scfh_pkg::FRAME_START_BYTE);
  wire logic       end_good      = bcc_ok_reg &&
                                   (i_rx_data == scfh_pkg::FRAME_END_BYTE);

  scfh_gap_timer #(
    .GAP_CYCLES     (GAP_CYCLES),
    .SILENCE_CYCLES (SILENCE_CYCLES)
  ) u_timer (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_restart  (i_rx_valid || enter_discard),
    .o_gap_over (gap_over),
    .o_silent   (silent)
  );

  scfh_frame_mem u_mem (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .mem_port   (mem_bus)
  );

  assign mem_bus.wr_en   = mem_we;
  assign mem_bus.wr_addr = idx_reg;
  assign mem_bus.wr_data = (state_reg == scfh_pkg::ST_FETCH) ? i_rd_data
                                                             : i_rx_data;
  assign mem_bus.rd_addr = idx_reg;

  // ====================================================================
  // Sequencer
  always_comb
  begin
    state_next     = state_reg;
    step_next      = step_reg;
    id_next        = id_reg;
    read_next      = read_reg;
    len_next       = len_reg;
    idx_next       = idx_reg;
    bcc_next       = bcc_reg;
    bcc_ok_next    = bcc_ok_reg;
    good_next      = good_reg;
    known_next     = known_reg;
    phase_next     = phase_reg;
    tx_valid_next  = tx_valid_reg && !i_tx_ready;
    tx_data_next   = tx_data_reg;
    cmd_valid_next = 1'b0;
    wr_valid_next  = 1'b0;
    wr_index_next  = wr_index_reg;
    wr_data_next   = wr_data_reg;
    mem_we         = 1'b0;
    unique case (state_reg)
      scfh_pkg::ST_IDLE:
        if (start_seen) // RQ1
        begin
          state_next = scfh_pkg::ST_ID;
          bcc_next   = 8'h00;
          idx_next   = 7'h00;
        end
      scfh_pkg::ST_ID:
        if (i_rx_valid) // RQ3
        begin
          id_next    = i_rx_data;
          bcc_next   = fold(bcc_reg, i_rx_data);
          state_next = scfh_pkg::ST_LEN;
        end
      scfh_pkg::ST_LEN:
        if (i_rx_valid) // RQ2 RQ3
        begin
          read_next  = i_rx_data[scfh_pkg::DIR_BIT];
          len_next   = i_rx_data[6:0];
          bcc_next   = fold(bcc_reg, i_rx_data);
          // Reads carry no data; length is the expected answer size
          if (i_rx_data[scfh_pkg::DIR_BIT] || i_rx_data[6:0] == 7'h00)
            state_next = scfh_pkg::ST_CHECK; // RQ14
          else
            state_next = scfh_pkg::ST_DATA;
        end
      scfh_pkg::ST_DATA:
        if (i_rx_valid) // RQ4
        begin
          mem_we   = 1'b1;
          bcc_next = fold(bcc_reg, i_rx_data); // RQ5
          idx_next = idx_reg + 7'h01;
          if (last_byte)
            state_next = scfh_pkg::ST_CHECK;
        end
      scfh_pkg::ST_CHECK:
        if (i_rx_valid)
        begin
          bcc_ok_next = (i_rx_data == bcc_reg); // RQ5
          state_next  = scfh_pkg::ST_END;
        end
      scfh_pkg::ST_END:
        if (i_rx_valid)
        begin
          // Surplus data shows up here as a wrong end byte
          good_next  = end_good; // RQ6 RQ9
          known_next = i_cmd_known;
          state_next = scfh_pkg::ST_ACK;
        end
      scfh_pkg::ST_ACK:
        if (tx_free) // RQ7
        begin
          tx_valid_next = 1'b1;
          tx_data_next  = good_reg ? scfh_pkg::ACK_BYTE
                                   : scfh_pkg::NAK_BYTE;
          state_next    = scfh_pkg::ST_ACK_WAIT;
        end
      scfh_pkg::ST_ACK_WAIT:
        if (tx_taken)
        begin
          idx_next   = 7'h00;
          phase_next = 1'b0;
          // Unknown ids are acknowledged but go no further
          if (!good_reg || !known_reg) // RQ13 RQ16
            state_next = scfh_pkg::ST_IDLE;
          else
          begin
            cmd_valid_next = 1'b1; // RQ20
            if (read_reg)
              state_next = scfh_pkg::ST_FETCH; // RQ12
            else if (len_reg == 7'h00)
              state_next = scfh_pkg::ST_IDLE;
            else
              state_next = scfh_pkg::ST_WRITE;
          end
        end
      scfh_pkg::ST_WRITE:
        // Two cycles a byte to cover the buffer read latency
        if (!phase_reg)
          phase_next = 1'b1;
        else
        begin
          wr_valid_next = 1'b1; // RQ17
          wr_index_next = idx_reg;
          wr_data_next  = rdata;
          idx_next      = idx_reg + 7'h01;
          phase_next    = 1'b0;
          if (last_byte)
            state_next = scfh_pkg::ST_IDLE;
        end
      scfh_pkg::ST_FETCH:
        if (idx_reg == len_reg) // RQ20
        begin
          state_next = scfh_pkg::ST_RESP;
          step_next  = scfh_pkg::STEP_START;
          idx_next   = 7'h00;
        end
        else if (i_rd_valid)
        begin
          mem_we   = 1'b1; // RQ8
          idx_next = idx_reg + 7'h01;
        end
      scfh_pkg::ST_RESP:
        // Loads only into an empty holding register: one idle cycle
        // between bytes gives the buffer time to present the next one
        if (tx_free)
        begin
          tx_valid_next = 1'b1;
          unique case (step_reg)
            scfh_pkg::STEP_START:
            begin
              tx_data_next = scfh_pkg::FRAME_START_BYTE; // RQ19
              step_next    = scfh_pkg::STEP_ID;
            end
            scfh_pkg::STEP_ID:
            begin
              tx_data_next = id_reg;
              bcc_next     = id_reg;
              step_next    = scfh_pkg::STEP_LEN;
            end
            scfh_pkg::STEP_LEN:
            begin
              tx_data_next = {1'b0, len_reg}; // RQ19
              bcc_next     = fold(bcc_reg, {1'b0, len_reg});
              step_next    = (len_reg == 7'h00) ? scfh_pkg::STEP_BCC
                                                : scfh_pkg::STEP_DATA;
            end
            scfh_pkg::STEP_DATA:
            begin
              tx_data_next = rdata; // RQ8
              bcc_next     = fold(bcc_reg, rdata);
              idx_next     = idx_reg + 7'h01;
              if (last_byte)
                step_next = scfh_pkg::STEP_BCC;
            end
            scfh_pkg::STEP_BCC:
            begin
              tx_data_next = bcc_reg;
              step_next    = scfh_pkg::STEP_END;
            end
            scfh_pkg::STEP_END:
            begin
              tx_data_next = scfh_pkg::FRAME_END_BYTE;
              state_next   = scfh_pkg::ST_IDLE;
            end
            default:
            begin
              tx_valid_next = 1'b0;
              state_next    = scfh_pkg::ST_IDLE;
            end
          endcase
        end
      scfh_pkg::ST_DISCARD:
        if (!i_rx_valid && silent) // RQ11
          state_next = scfh_pkg::ST_IDLE;
      default:
        state_next = scfh_pkg::ST_IDLE;
    endcase
    // A byte in the same cycle as the time-out still counts
    if (in_frame(state_reg) && !i_rx_valid && gap_over)
      state_next = scfh_pkg::ST_DISCARD; // RQ10
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_reg     <= scfh_pkg::ST_IDLE;
      step_reg      <= scfh_pkg::STEP_START;
      id_reg        <= 8'h00;
      read_reg      <= 1'b0;
      len_reg       <= 7'h00;
      idx_reg       <= 7'h00;
      bcc_reg       <= 8'h00;
      bcc_ok_reg    <= 1'b0;
      good_reg      <= 1'b0;
      known_reg     <= 1'b0;
      phase_reg     <= 1'b0;
      tx_valid_reg  <= 1'b0;
      tx_data_reg   <= 8'h00;
      cmd_valid_reg <= 1'b0;
      wr_valid_reg  <= 1'b0;
      wr_index_reg  <= 7'h00;
      wr_data_reg   <= 8'h00;
    end
    else
    begin
      state_reg     <= state_next;
      step_reg      <= step_next;
      id_reg        <= id_next;
      read_reg      <= read_next;
      len_reg       <= len_next;
      idx_reg       <= idx_next;
      bcc_reg       <= bcc_next;
      bcc_ok_reg    <= bcc_ok_next;
      good_reg      <= good_next;
      known_reg     <= known_next;
      phase_reg     <= phase_next;
      tx_valid_reg  <= tx_valid_next;
      tx_data_reg   <= tx_data_next;
      cmd_valid_reg <= cmd_valid_next;
      wr_valid_reg  <= wr_valid_next;
      wr_index_reg  <= wr_index_next;
      wr_data_reg   <= wr_data_next;
    end
  end

  assign o_tx_valid  = tx_valid_reg;
  assign o_tx_data   = tx_data_reg;
  assign o_cmd_valid = cmd_valid_reg;
  assign o_cmd_id    = id_reg;
  assign o_cmd_read  = read_reg;
  assign o_cmd_len   = len_reg;
  assign o_wr_valid  = wr_valid_reg;
  assign o_wr_index  = wr_index_reg;
  assign o_wr_data   = wr_data_reg;
  assign o_rd_req    = (state_reg == scfh_pkg::ST_FETCH) &&
                       (idx_reg != len_reg);

  // ====================================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  start_hunt_a: assert property ( // RQ1
    state_reg == scfh_pkg::ST_IDLE && start_seen
    |=> state_reg == scfh_pkg::ST_ID)
    else $error("start byte not taken");
  frame_descriptor_split_a: assert property ( // RQ2
    state_reg == scfh_pkg::ST_LEN && i_rx_valid
    |=> len_reg == $past(i_rx_data[6:0]) && read_reg == $past(i_rx_data[7]))
    else $error("descriptor split wrong");
  data_count_a: assert property ( // RQ4
    state_reg == scfh_pkg::ST_DATA && i_rx_valid && last_byte
    |=> state_reg == scfh_pkg::ST_CHECK && idx_reg == len_reg)
    else $error("data count wrong");
  check_fold_a: assert property ( // RQ5
    state_reg == scfh_pkg::ST_DATA && i_rx_valid
    |=> bcc_reg == ($past(bcc_reg) ^ $past(i_rx_data)))
    else $error("check byte fold wrong");
  answer_code_a: assert property ( // RQ9
    state_reg == scfh_pkg::ST_END && i_rx_valid && !end_good
    |=> ##1 o_tx_valid && o_tx_data == scfh_pkg::NAK_BYTE)
    else $error("bad frame not refused");
  ack_code_a: assert property ( // RQ7
    state_reg == scfh_pkg::ST_ACK_WAIT |-> o_tx_valid &&
    (o_tx_data == scfh_pkg::ACK_BYTE || o_tx_data == scfh_pkg::NAK_BYTE))
    else $error("answer code wrong");
  gap_discard_a: assert property ( // RQ10
    in_frame(state_reg) && gap_over && !i_rx_valid
    |=> state_reg == scfh_pkg::ST_DISCARD)
    else $error("gap time-out missed");
  silence_idle_a: assert property ( // RQ11
    state_reg == scfh_pkg::ST_DISCARD && !silent
    |=> state_reg == scfh_pkg::ST_DISCARD)
    else $error("discard left early");
  unknown_read_a: assert property ( // RQ13
    state_reg == scfh_pkg::ST_ACK_WAIT && tx_taken && !known_reg
    |=> state_reg == scfh_pkg::ST_IDLE && !o_cmd_valid)
    else $error("unknown id went on");
  read_no_data_a: assert property ( // RQ14
    state_reg == scfh_pkg::ST_LEN && i_rx_valid && i_rx_data[7]
    |=> state_reg == scfh_pkg::ST_CHECK)
    else $error("read frame took data");
  store_write_a: assert property ( // RQ16
    o_wr_valid |-> known_reg && good_reg && !read_reg)
    else $error("write to store not allowed");
  resp_flag_a: assert property ( // RQ19
    state_reg == scfh_pkg::ST_RESP && step_reg == scfh_pkg::STEP_LEN &&
    tx_free |=> o_tx_valid && !o_tx_data[7])
    else $error("response flag not cleared");

  ack_seen_c: cover property (
    tx_taken && state_reg == scfh_pkg::ST_ACK_WAIT && good_reg);
  nak_seen_c: cover property (
    tx_taken && state_reg == scfh_pkg::ST_ACK_WAIT && !good_reg);
  resp_done_c: cover property (
    state_reg == scfh_pkg::ST_RESP && step_reg == scfh_pkg::STEP_END &&
    tx_free);
  discard_c: cover property (state_reg == scfh_pkg::ST_DISCARD && silent);
  write_c: cover property (o_wr_valid);

endmodule

`default_nettype wire

// file: tb/scfh_host_model.sv
// Host end of the byte link: sends frame bytes, sinks answer bytes.
// Assumes the bench calls send_byte and reads the got queue.
`default_nettype none
module scfh_host_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_slow,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output var  logic       o_rx_valid,
  output var  logic [7:0] o_rx_data,
  output var  logic       o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_tx_ready = 1'b1;
  end
  // ==================================================================
  // Answer sink
  // A slow host accepts only on every other cycle
  always @(negedge i_core_clk)
    o_tx_ready <= !i_slow || !o_tx_ready;
  always @(posedge i_core_clk)
    if (i_tx_valid && o_tx_ready)
      got.push_back(i_tx_data);
  // ==================================================================
  // Byte sender
  // Line shows the inverted byte between strobes, never a stale copy
  task automatic send_byte(input logic [7:0] b);
    @(negedge i_core_clk);
    o_rx_valid = 1'b1;
    o_rx_data  = b;
    @(negedge i_core_clk);
    o_rx_valid = 1'b0;
    o_rx_data  = ~b;
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench: table of frames, then gap and discard cases.
// Assumes short gap and silence counts handed to the design.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned GAP = 50;
  localparam int unsigned SIL = 80;
  typedef struct {
    logic [63:0] f;
    int          fn;
    logic [63:0] e;
    int          en;
    int          wn;
    logic        slow;
  } scfh_row_type;
  // Frame bytes and expected answer bytes, first byte at the top
  scfh_row_type rows[8] = '{
    '{64'h0246_0102_4503_0000, 6, 64'h0600_0000_0000_0000, 1, 1, 0},
    '{64'h0243_82C1_0300_0000, 5, 64'h0602_4302_A1B2_5203, 8, 0, 1},
    '{64'h02C0_8141_0300_0000, 5, 64'h0600_0000_0000_0000, 1, 0, 0},
    '{64'h0246_0102_4403_0000, 6, 64'h1500_0000_0000_0000, 1, 0, 0},
    '{64'h0246_0102_4504_0000, 6, 64'h1500_0000_0000_0000, 1, 0, 1},
    '{64'h0250_0107_5603_0000, 6, 64'h0600_0000_0000_0000, 1, 0, 0},
    '{64'h0243_80C3_0300_0000, 5, 64'h0602_4300_4303_0000, 6, 0, 0},
    '{64'h0246_81C7_0300_0000, 5, 64'h0602_4601_0245_0300, 7, 0, 0}};
  logic       core_clk = 1'b0;
  logic       arst_n   = 1'b0;
  logic       slow     = 1'b0;
  logic       rx_valid, tx_valid, tx_ready, cmd_valid, cmd_read;
  logic       wr_valid, rd_req, known;
  logic       rd_valid = 1'b0;
  logic [7:0] rx_data, tx_data, cmd_id, wr_data;
  logic [7:0] rd_data  = 8'h00;
  logic [7:0] w_dat;
  logic       cmd_exp;
  logic [6:0] cmd_len, wr_index, w_idx;
  int         err_total, checks_done, wcnt, rd_k, ccnt;
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  scfh_top #(.GAP_CYCLES(GAP), .SILENCE_CYCLES(SIL)) DUT (
    .i_core_clk(core_clk), .i_arst_n(arst_n), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .i_tx_ready(tx_ready), .o_cmd_valid(cmd_valid), .o_cmd_id(cmd_id),
    .o_cmd_read(cmd_read), .o_cmd_len(cmd_len), .i_cmd_known(known),
    .o_wr_valid(wr_valid), .o_wr_index(wr_index), .o_wr_data(wr_data),
    .o_rd_req(rd_req), .i_rd_valid(rd_valid), .i_rd_data(rd_data));
  scfh_host_model host (
    .i_core_clk(core_clk), .i_slow(slow), .i_tx_valid(tx_valid),
    .i_tx_data(tx_data), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_tx_ready(tx_ready));
  // ==================================================================
  // Parameter store stand-in: ids 0x43 and 0x46 are known
  assign known = (cmd_id === 8'h43) || (cmd_id === 8'h46);
  always @(negedge core_clk)
    if (rd_req === 1'b1 && !rd_valid && rd_k < int'(cmd_len))
    begin
      rd_valid <= 1'b1;
      // Id 0x46 reads back the last byte written to any id
      rd_data  <= (cmd_id === 8'h46) ? w_dat :
                  (rd_k == 0) ? 8'hA1 : 8'hB2;
      rd_k     <= rd_k + 1;
    end
    else
    begin
      rd_valid <= 1'b0;
      rd_data  <= ~rd_data;
    end
  always @(posedge core_clk)
    if (wr_valid === 1'b1)
    begin
      wcnt  <= wcnt + 1;
      w_idx <= wr_index;
      w_dat <= wr_data;
    end
  always @(posedge core_clk)
    if (cmd_valid === 1'b1)
      ccnt <= ccnt + 1;
  // ==================================================================
  // Helpers
  task automatic chk(input string nm, input logic [7:0] ex,
                     input logic [7:0] sn);
    checks_done++;
    if (sn !== ex)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Pause after the start byte stretches the first gap
  task automatic send_row(input int i, input int pause);
    host.got.delete();
    wcnt = 0;
    ccnt = 0;
    rd_k = 0;
    slow = rows[i].slow;
    for (int k = 0; k < rows[i].fn; k++)
    begin
      host.send_byte(rows[i].f[63-8*k -: 8]);
      if (k == 0)
        repeat (pause) @(negedge core_clk);
    end
    // Host gives up on a missing answer after a bounded wait
    for (int t = 0; t < 300 && host.got.size() < rows[i].en; t++)
      @(posedge core_clk);
    // Extra time so that a surplus answer byte would show
    repeat (40) @(posedge core_clk);
  endtask
  // ==================================================================
  // Main sequence
  initial
  begin
    repeat (7) @(negedge core_clk);
    chk("reset out", 8'h00, {4'h0, tx_valid, cmd_valid, wr_valid, rd_req});
    @(negedge core_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    foreach (rows[i])
    begin
      send_row(i, 0);
      for (int k = 0; k < rows[i].en; k++)
        chk("tx byte", rows[i].e[63-8*k -: 8], host.got[k]);
      chk("tx count", 8'(rows[i].en), 8'(host.got.size()));
      chk("writes", 8'(rows[i].wn), 8'(wcnt));
      chk("cmd id", rows[i].f[55:48], cmd_id);
      chk("cmd dirlen", rows[i].f[47:40], {cmd_read, cmd_len});
      // Hand-over only for an acknowledged frame with a known id
      cmd_exp = (rows[i].e[63:56] == 8'h06) &&
                ((rows[i].f[55:48] == 8'h43) ||
                 (rows[i].f[55:48] == 8'h46));
      chk("cmd pulses", {7'h00, cmd_exp}, 8'(ccnt));
      if (rows[i].wn == 1)
      begin
        chk("wr data", rows[i].f[39:32], w_dat);
        chk("wr index", 8'h00, {1'b0, w_idx});
      end
    end
    send_row(0, GAP - 3);
    chk("gap inside", 8'h06, host.got[0]);
    send_row(0, GAP + 4);
    chk("discard", 8'h00, 8'(host.got.size()));
    repeat (SIL + 4) @(negedge core_clk);
    send_row(0, 0);
    chk("after silence", 8'h06, host.got[0]);
    give_verdict();
  end
  initial
  begin
    #(40 * 30000);
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
